// ==== shp_pkg.sv ====
// Purpose: shared types and constants of the spi host register port
// Assumes: system clock of 100 MHz
// Notes: strap codes are {hi, lo}
`default_nettype none
package shp_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned SPI_MAX_KBPS = 10000;
   // a serial bit at the top rate spans this many system cycles
   localparam int unsigned SPI_BIT_CYC = (CLK_MHZ * 1000) / SPI_MAX_KBPS;
   localparam logic [6:0] FIFO_ADDR_RST = 7'h05;
   localparam logic [7:0] READ_FILLER = 8'h00;
   localparam int unsigned ADDR_DIR_BIT = 0;
   localparam logic [2:0] BIT_CNT_RST = 3'h0;

   typedef enum logic [1:0] {
      SHP_IF_UART = 2'b00,
      SHP_IF_I2C = 2'b01,
      SHP_IF_SPI = 2'b10,
      SHP_IF_I2CL = 2'b11
   } shp_if_t;

   typedef enum logic [1:0] {
      SHP_ST_ADDR = 2'b00,
      SHP_ST_WRITE = 2'b01,
      SHP_ST_READ = 2'b11
   } shp_state_t;

   // register-side request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] data;
   } shp_req_t;
endpackage
`default_nettype wire

// ==== shp_sync.sv ====
// Purpose: three-stage synchroniser with agreement of the last two stages
// Assumes: input asynchronous to sys_clk_i
// Notes: the first stage feeds only the second
`default_nettype none
module shp_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [WIDTH-1:0] lvl_d;

   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         lvl_q <= RST_VAL;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_o = lvl_q;
endmodule
`default_nettype wire

// ==== shp_port.sv ====
// Purpose: spi slave host port with strap decode and register access
// Assumes: sck at most 10 Mbit/s, sampled by the 100 MHz system clock
// Notes: register file lives outside; reads answered from rd_data_i
// Functional notes
// - straps captured once after reset release
// - strap code selects uart, spi or i2c
// - pins a..d serve mosi, sck, miso, select
// - slave only, sck always an input
// - correct up to 10 Mbit/s serial rate
// - bytes shifted most significant bit first
// - mosi captured on rising sck
// - miso updated on falling sck
// - address byte: bit0 read flag, bits 7..1 address
// - read burst returns data of previous address
// - write burst: one address then data bytes
// - write address increments per data byte
// - fifo address does not increment
`default_nettype none
module shp_port #(
   parameter logic [6:0] FIFO_ADDR = shp_pkg::FIFO_ADDR_RST
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic host_if_strap_lo_i,
   input wire logic host_if_strap_hi_i,
   input wire logic shared_if_pin_a_i,
   input wire logic shared_if_pin_b_i,
   input wire logic shared_if_pin_d_i,
   output logic shared_if_pin_c_o,
   output logic shared_if_pin_c_oe_n_o,
   output logic [1:0] if_type_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [6:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] rd_data_i
);
   // mosi, sck, select_n after the three-stage filter
   logic [2:0] pins_s;
   logic mosi_s, sck_s, sel_n_s;
   // a 50 ns sck phase still leaves two agreeing filter samples
   shp_sync #(.WIDTH(3), .RST_VAL(3'h4)) u_sync (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .async_i({shared_if_pin_d_i, shared_if_pin_b_i, shared_if_pin_a_i}),
      .level_o(pins_s)
   );
   assign mosi_s = pins_s[0];
   assign sck_s = pins_s[1];
   assign sel_n_s = pins_s[2];

   // strap capture, one shot after reset release
   logic strap_done_q, strap_done_d;
   logic [1:0] if_q, if_d;
   logic [1:0] strap_s;
   shp_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_strap (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .async_i({host_if_strap_hi_i, host_if_strap_lo_i}),
      .level_o(strap_s)
   );
   logic [2:0] strap_cnt_q, strap_cnt_d;

   always_comb begin
      strap_cnt_d = strap_cnt_q;
      strap_done_d = strap_done_q;
      if_d = if_q;
      // wait for the filter to settle before latching
      if (!strap_done_q) begin
         strap_cnt_d = strap_cnt_q + 3'h1;
         // filter output is valid only after its fourth edge
         if (strap_cnt_q == 3'h4) begin
            strap_done_d = 1'b1;
            if_d = strap_s;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strap_cnt_q <= 3'h0;
         strap_done_q <= 1'b0;
         if_q <= shp_pkg::SHP_IF_UART;
      end else begin
         strap_cnt_q <= strap_cnt_d;
         strap_done_q <= strap_done_d;
         if_q <= if_d;
      end
   end

   logic spi_en;
   assign spi_en = strap_done_q && (if_q == shp_pkg::SHP_IF_SPI);

   // serial engine
   logic sck_prev_q, sel_prev_q;
   logic rise, fall, sel_start;
   assign rise = sck_s && !sck_prev_q;
   assign fall = !sck_s && sck_prev_q;
   assign sel_start = !sel_n_s && sel_prev_q;

   shp_pkg::shp_state_t st_q, st_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] rx_q, rx_d;
   logic [7:0] tx_q, tx_d;
   logic [6:0] addr_q, addr_d;
   logic miso_q, miso_d;
   logic oe_n_q, oe_n_d;
   shp_pkg::shp_req_t req_q, req_d;
   logic load_q, load_d;
   logic [7:0] byte_in;

   assign byte_in = {rx_q[6:0], mosi_s};

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      rx_d = rx_q;
      tx_d = tx_q;
      addr_d = addr_q;
      miso_d = miso_q;
      oe_n_d = 1'b1;
      req_d = '0;
      req_d.addr = req_q.addr;
      req_d.data = req_q.data;
      load_d = 1'b0;
      if (spi_en && !sel_n_s) begin
         oe_n_d = 1'b0;
      end
      if (load_q) begin
         tx_d = rd_data_i;
      end
      if (!spi_en || sel_n_s || sel_start) begin
         st_d = shp_pkg::SHP_ST_ADDR;
         bit_d = shp_pkg::BIT_CNT_RST;
         rx_d = '0;
      end else begin
         if (rise) begin
            rx_d = byte_in;
            bit_d = bit_q + 3'd1;
            if (bit_q == 3'd7) begin
               unique case (st_q)
                  shp_pkg::SHP_ST_ADDR: begin
                     addr_d = byte_in[7:1];
                     if (byte_in[shp_pkg::ADDR_DIR_BIT]) begin
                        st_d = shp_pkg::SHP_ST_READ;
                        req_d.rd = 1'b1;
                        req_d.addr = byte_in[7:1];
                        load_d = 1'b1;
                     end else begin
                        st_d = shp_pkg::SHP_ST_WRITE;
                     end
                  end
                  shp_pkg::SHP_ST_WRITE: begin
                     req_d.wr = 1'b1;
                     req_d.addr = addr_q;
                     req_d.data = byte_in;
                     if (addr_q != FIFO_ADDR) begin
                        addr_d = addr_q + 7'd1;
                     end
                  end
                  shp_pkg::SHP_ST_READ: begin
                     // each read slot other than READ_FILLER carries the next address
                     if (byte_in != shp_pkg::READ_FILLER) begin
                        req_d.rd = 1'b1;
                        req_d.addr = byte_in[7:1];
                        load_d = 1'b1;
                     end
                  end
               endcase
            end
         end
         if (fall) begin
            miso_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
            if (load_q) begin
               tx_d = rd_data_i;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sck_prev_q <= 1'b0;
         sel_prev_q <= 1'b1;
         st_q <= shp_pkg::SHP_ST_ADDR;
         bit_q <= shp_pkg::BIT_CNT_RST;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         addr_q <= 7'h00;
         miso_q <= 1'b0;
         oe_n_q <= 1'b1;
         req_q <= '0;
         load_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
         sel_prev_q <= sel_n_s;
         st_q <= st_d;
         bit_q <= bit_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         addr_q <= addr_d;
         miso_q <= miso_d;
         oe_n_q <= oe_n_d;
         req_q <= req_d;
         load_q <= load_d;
      end
   end

   assign shared_if_pin_c_o = miso_q;
   assign shared_if_pin_c_oe_n_o = oe_n_q;
   assign if_type_o = if_q;
   assign reg_wr_o = req_q.wr;
   assign reg_rd_o = req_q.rd;
   assign reg_addr_o = req_q.addr;
   assign reg_wdata_o = req_q.data;

   property p_strap_once;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      strap_done_q |=> $stable(if_q);
   endproperty
   a_strap_once: assert property (p_strap_once) else $error("strap moved");

   property p_no_io_unless_spi;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      !spi_en |=> !reg_wr_o && !reg_rd_o && oe_n_q;
   endproperty
   a_no_io_unless_spi: assert property (p_no_io_unless_spi)
      else $error("spi active off mode");

   property p_oe_follows_sel;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      sel_n_s |=> oe_n_q;
   endproperty
   a_oe_follows_sel: assert property (p_oe_follows_sel)
      else $error("miso driven while deselected");

   property p_miso_on_fall;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      !fall |=> $stable(miso_q);
   endproperty
   a_miso_on_fall: assert property (p_miso_on_fall)
      else $error("miso moved off falling edge");

   property p_bit_on_rise;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (!rise && !sel_n_s && spi_en && !sel_start) |=> $stable(bit_q);
   endproperty
   a_bit_on_rise: assert property (p_bit_on_rise)
      else $error("bit count moved off rising edge");

   property p_restart;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      sel_start |=> bit_q == 3'd0 && st_q == shp_pkg::SHP_ST_ADDR;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");

   property p_incr;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      reg_wr_o && reg_addr_o != FIFO_ADDR && st_q == shp_pkg::SHP_ST_WRITE
      |-> addr_q == reg_addr_o + 7'd1;
   endproperty
   a_incr: assert property (p_incr) else $error("no increment");

   property p_fifo_hold;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      reg_wr_o && reg_addr_o == FIFO_ADDR && st_q == shp_pkg::SHP_ST_WRITE
      |-> addr_q == FIFO_ADDR;
   endproperty
   a_fifo_hold: assert property (p_fifo_hold) else $error("fifo incr");

   property p_rd_load;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      reg_rd_o |=> tx_q == $past(rd_data_i);
   endproperty
   a_rd_load: assert property (p_rd_load) else $error("read not loaded");

   // last bit of an address byte that asks for a read
   sequence s_rd_addr_byte;
      rise && bit_q == 3'h7 && st_q == shp_pkg::SHP_ST_ADDR &&
      byte_in[shp_pkg::ADDR_DIR_BIT] && spi_en && !sel_n_s && !sel_start;
   endsequence
   sequence s_rd_issued;
      reg_rd_o && reg_addr_o == rx_q[7:1];
   endsequence
   property p_rd_issue;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_rd_addr_byte |=> s_rd_issued;
   endproperty
   a_rd_issue: assert property (p_rd_issue)
      else $error("read request missing");

   // last bit of a data byte inside a write burst
   sequence s_wr_data_byte;
      rise && bit_q == 3'h7 && st_q == shp_pkg::SHP_ST_WRITE &&
      spi_en && !sel_n_s && !sel_start;
   endsequence
   sequence s_wr_issued;
      reg_wr_o && reg_wdata_o == rx_q;
   endsequence
   property p_wr_issue;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_wr_data_byte |=> s_wr_issued;
   endproperty
   a_wr_issue: assert property (p_wr_issue)
      else $error("write request missing");
endmodule
`default_nettype wire

// ==== shp_host_model.sv ====
// Purpose: spi master host that drives the port's serial pins
// Assumes: sys_clk_i of 100 MHz paces the serial clock
// Notes: mode 0, 80 ns half periods, msb first
`default_nettype none
module shp_host_model (
   input wire logic sys_clk_i,
   input wire logic miso_i,
   output logic mosi_o,
   output logic sck_o,
   output logic sel_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      mosi_o = 1'b0;
      sck_o = 1'b0;
      sel_n_o = 1'b1;
   end
   task automatic half();
      repeat (8) @(negedge sys_clk_i);
   endtask
   task automatic open_frame();
      sel_n_o = 1'b0;
      half();
   endtask
   task automatic close_frame();
      half();
      sel_n_o = 1'b1;
      // released line must not keep showing the last bit
      mosi_o = ~mosi_o;
      half();
   endtask
   // only the host makes sck; 160 ns per bit stays under the top rate
   task automatic xfer(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i >= 8 - n; i--) begin
         mosi_o = tx[i];
         half();
         sck_o = 1'b1;
         rx[i] = miso_i;
         half();
         sck_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench of the spi host register port
// Assumes: host model paces all serial traffic
// Notes: register file modelled by the mem array
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, s_lo, s_hi, mosi, sck, sel_n, pin_c, oe_n, miso, miso_q;
   logic wr, rd;
   logic [1:0] if_type;
   logic [6:0] addr;
   logic [7:0] wdata, rdata;
   logic [7:0] mem [128];
   logic [14:0] obs [$];
   logic [14:0] exp_q [$];
   int compares, miscompares, cycles, rd_cnt;
   shp_port DUT (.sys_clk_i(clk), .nrst_i(nrst), .host_if_strap_lo_i(s_lo),
      .host_if_strap_hi_i(s_hi), .shared_if_pin_a_i(mosi),
      .shared_if_pin_b_i(sck), .shared_if_pin_d_i(sel_n),
      .shared_if_pin_c_o(pin_c), .shared_if_pin_c_oe_n_o(oe_n),
      .if_type_o(if_type), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .rd_data_i(rdata));
   shp_host_model host (.sys_clk_i(clk), .miso_i(miso), .mosi_o(mosi),
      .sck_o(sck), .sel_n_o(sel_n));
   assign rdata = mem[addr];
   assign miso = oe_n ? ~miso_q : pin_c;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (!oe_n) miso_q <= pin_c;
      if (wr) obs.push_back({addr, wdata});
      if (rd) rd_cnt++;
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic do_reset(input logic [1:0] straps);
      @(negedge clk);
      nrst = 1'b0;
      {s_hi, s_lo} = straps;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (10) @(negedge clk);
   endtask
   task automatic cmp_writes();
      check(16'(obs.size()), 16'(exp_q.size()));
      while (exp_q.size() > 0 && obs.size() > 0)
         check({1'b0, obs.pop_front()}, {1'b0, exp_q.pop_front()});
      obs.delete();
      exp_q.delete();
   endtask
   initial begin
      logic [7:0] rx, d;
      logic [6:0] a;
      logic [6:0] ra [3];
      logic [1:0] code;
      nrst = 1'b0;
      s_lo = 1'b0;
      s_hi = 1'b0;
      miso_q = 1'b0;
      compares = 0;
      miscompares = 0;
      cycles = 0;
      rd_cnt = 0;
      void'($urandom(13));
      foreach (mem[i]) mem[i] = 8'($urandom());
      // spi mode comes last so later traffic is live
      for (int s = 0; s < 4; s++) begin
         // order 00 01 11 10 leaves the spi straps in place
         code = 2'(s ^ (s >> 1));
         do_reset(code);
         check({14'h0, if_type}, {14'h0, code});
         host.open_frame();
         check({15'h0, oe_n}, {15'h0, code != 2'h2});
         host.xfer(8'h14, 8, rx);
         host.xfer(8'h5a, 8, rx);
         host.close_frame();
         if (code == 2'h2) exp_q.push_back({7'h0a, 8'h5a});
         cmp_writes();
      end
      for (int k = 0; k < 2; k++) begin
         a = k ? shp_pkg::FIFO_ADDR_RST : 7'($urandom_range(60, 10));
         host.open_frame();
         host.xfer({a, 1'b0}, 8, rx);
         for (int i = 0; i < 3; i++) begin
            d = 8'($urandom());
            host.xfer(d, 8, rx);
            exp_q.push_back({a + (k ? 7'h0 : 7'(i)), d});
         end
         host.close_frame();
         cmp_writes();
      end
      // stray half byte must not shift the next frame
      host.open_frame();
      host.xfer(8'hff, 4, rx);
      host.close_frame();
      host.open_frame();
      host.xfer(8'h40, 8, rx);
      host.xfer(8'hc3, 8, rx);
      host.close_frame();
      exp_q.push_back({7'h20, 8'hc3});
      cmp_writes();
      rd_cnt = 0;
      host.open_frame();
      check({15'h0, oe_n}, 16'h0);
      for (int i = 0; i < 4; i++) begin
         if (i < 3) ra[i] = 7'($urandom_range(127, 64));
         d = (i < 3) ? {ra[i], 1'b1} : shp_pkg::READ_FILLER;
         host.xfer(d, 8, rx);
         if (i > 0) check({8'h0, rx}, {8'h0, mem[ra[i-1]]});
      end
      host.close_frame();
      check(16'(rd_cnt), 16'd3);
      cmp_writes();
      summarize();
   end
endmodule
`default_nettype wire
